// *** hdl/hsc_counter.sv ***
// Four-channel high-speed pulse counter with APB registers and an interrupt pin.
// Assumes asynchronous pins and an APB master on core_clk.
//
// Functional notes
// R1 - Pin two gives events only in interrupt mode.
// R2 - A pin two event raises handler 142.
// R3 - Software picks the edge, then unmasks; masked, nothing starts.
// R4 - Four independent channels, each with own pins.
// R5 - Methods: incremental, quadrature 4x, up/down, pulse plus direction.
// R6 - Counts 50 kHz quadrature, 100 kHz other methods.
// R7 - Present value is readable as position data.
// R8 - Reaching the preset raises the channel's interrupt.
// R9 - Software starts and stops each channel; stopped holds value.
// R10 - Pulse frequency is measured and readable.
// R11 - 32-bit value in two 16-bit halves; ring wraps at maximum.
// R12 - Reset by software bit, or by phase Z while that bit is set.
// R13 - Pin two takes rising edges by default; one edge, one request.
`timescale 1ns/1ps
module hsc_counter
    import hsc_pkg::*;
#(
    parameter int unsigned GateCycles = GATE_CYCLES
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // APB slave
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Counter pins
    input  wire logic [CH_COUNT-1:0] chanA,
    input  wire logic [CH_COUNT-1:0] chanB,
    input  wire logic [CH_COUNT-1:0] chanZ,
    input  wire logic                interrupt_pin_two,
    // Interrupt
    output logic                     irq,
    output logic      [7:0]          irqVector
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rstSync;
    logic       rstn;

    // Assert at once, release two edges later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    assign rstn = rstSync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int PIN_W = 3 * CH_COUNT + 1;

    logic [PIN_W-1:0]    pinSync;
    logic [CH_COUNT-1:0] syncA;
    logic [CH_COUNT-1:0] syncB;
    logic [CH_COUNT-1:0] syncZ;
    logic [CH_COUNT-1:0] prevZ;
    logic                syncPin2;
    logic                prevPin2;

    hsc_sync #(
        .W        (PIN_W)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      ({interrupt_pin_two, chanZ, chanB, chanA}),  // R6
        .dout     (pinSync)
    );

    assign {syncPin2, syncZ, syncB, syncA} = pinSync;

    // Previous levels for Z and pin two edges
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prevZ    <= '0;
            prevPin2 <= 1'b0;
        end else begin
            prevZ    <= syncZ;
            prevPin2 <= syncPin2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [2:0]  chSlot;
    logic [1:0]  chIdx;
    logic [4:0]  chOfs;
    logic        apbSetup;
    logic        apbWrite;
    logic        isTop;
    logic        isChan;
    logic        mapped;

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite;    // Write lands at the access edge
    assign chSlot   = paddr[7:5];
    assign chIdx    = 2'(chSlot - CH_FIRST);
    assign chOfs    = paddr[4:0];
    assign isTop    = paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_MASK ||
                      paddr == ADDR_PINCFG || paddr == ADDR_VECTOR;
    assign isChan   = paddr[11:8] == 4'h0 && chSlot >= CH_FIRST && chSlot <= CH_LAST &&
                      paddr[1:0] == 2'b00 && chOfs <= OFS_FREQ;
    assign mapped   = isTop || isChan;

    // Global write strobes
    logic wrCtrl;
    logic wrStat;
    logic wrMask;
    logic wrPinCfg;

    assign wrCtrl   = apbWrite && paddr == ADDR_CTRL;
    assign wrStat   = apbWrite && paddr == ADDR_STAT;
    assign wrMask   = apbWrite && paddr == ADDR_MASK;
    assign wrPinCfg = apbWrite && paddr == ADDR_PINCFG;

    ////////////////////////////////////////////////////////////////////////////
    // Global registers
    logic [7:0]            ctrl;
    logic [STAT_WIDTH-1:0] mask;
    logic [1:0]            pinCfg;
    logic [CH_COUNT-1:0]   runBit;
    logic [CH_COUNT-1:0]   rstBit;

    // Run and reset bits, status mask, pin mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl   <= RST_CTRL;
            mask   <= RST_MASK;
            pinCfg <= RST_PINCFG;                                  // R13
        end else begin
            if (wrCtrl)
                ctrl <= pwdata[7:0];
            if (wrMask)
                mask <= pwdata[STAT_WIDTH-1:0];                    // R3
            if (wrPinCfg)
                pinCfg <= pwdata[1:0];                             // R1
        end
    end

    assign runBit = ctrl[CTRL_RUN_LSB +: CH_COUNT];
    assign rstBit = ctrl[CTRL_RST_LSB +: CH_COUNT];

    ////////////////////////////////////////////////////////////////////////////
    // Frequency gate
    logic [31:0] gateCnt;
    logic        gateTick;

    // One pulse per measuring window
    assign gateTick = gateCnt == 32'(GateCycles - 1);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gateCnt <= 32'h0;
        end else begin
            gateCnt <= gateTick ? 32'h0 : 32'(gateCnt + 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter channels
    logic [3:0]          mode    [CH_COUNT];
    logic [31:0]         pv      [CH_COUNT];
    logic [31:0]         preset  [CH_COUNT];
    logic [31:0]         ringMax [CH_COUNT];
    logic [31:0]         freq    [CH_COUNT];
    logic [31:0]         edgeCnt [CH_COUNT];
    logic [CH_COUNT-1:0] matchEv;

    for (genvar c = 0; c < CH_COUNT; c++) begin : g_ch
        logic        up;
        logic        dn;
        logic        stepUp;
        logic        stepDn;
        logic        step;
        logic        zRise;
        logic        clr;
        logic        sel;
        logic        ldLo;
        logic        ldHi;
        logic [31:0] next_pv;

        // Method decode; Z pin doubles as reset input
        hsc_decode u_dec (
            .core_clk (core_clk),
            .rstn     (rstn),
            .method   (mode[c][1:0]),
            .inA      (syncA[c]),
            .inB      (syncB[c]),
            .up       (up),
            .dn       (dn)
        );                                                          // R5

        // Simultaneous up and down pulses cancel
        assign stepUp  = up && !dn;
        assign stepDn  = dn && !up;
        assign step    = runBit[c] && (stepUp || stepDn);           // R9
        assign zRise   = syncZ[c] && !prevZ[c];
        assign clr     = rstBit[c] && (!mode[c][MODE_ZRST_BIT] || zRise);   // R12
        assign sel     = apbWrite && isChan && chIdx == 2'(c);
        assign ldLo    = sel && chOfs == OFS_PVLO;
        assign ldHi    = sel && chOfs == OFS_PVHI;

        // Clear beats a software load, a load beats a count
        assign next_pv = clr  ? 32'h0 :
                         ldLo ? {pv[c][31:16], pwdata[15:0]} :
                         ldHi ? {pwdata[15:0], pv[c][15:0]} :
                         step ? hsc_step(pv[c], stepUp, mode[c][MODE_RING_BIT], ringMax[c]) :
                         pv[c];                                     // R11

        // Preset hit needs a count step and no clear; a load in that cycle is compared instead
        assign matchEv[c] = step && !clr && next_pv == preset[c];   // R8

        // Configuration
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                mode[c]    <= RST_MODE;
                preset[c]  <= RST_PRESET;
                ringMax[c] <= RST_RING;
            end else begin
                if (sel && chOfs == OFS_MODE)
                    mode[c] <= pwdata[3:0];
                if (sel && chOfs == OFS_PRESET)
                    preset[c] <= pwdata;
                if (sel && chOfs == OFS_RING)
                    ringMax[c] <= pwdata;
            end
        end

        // Present value
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                pv[c] <= 32'h0;
            end else begin
                pv[c] <= next_pv;                                   // R7
            end
        end

        // Counts input pulses even while stopped, so speed stays visible
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                edgeCnt[c] <= 32'h0;
                freq[c]    <= 32'h0;
            end else if (gateTick) begin
                edgeCnt[c] <= 32'h0;
                freq[c]    <= 32'(edgeCnt[c] + {31'h0, up || dn});  // R10
            end else if (up || dn) begin
                edgeCnt[c] <= 32'(edgeCnt[c] + 32'h1);
            end
        end
    end                                                              // R4

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin two
    logic pin2Ev;

    // Falling edge only when chosen; latch option is not offered
    assign pin2Ev = pinCfg[PCFG_INT_BIT] &&
                    (pinCfg[PCFG_FALL_BIT] ? (!syncPin2 && prevPin2)
                                           : (syncPin2 && !prevPin2));   // R1 R13

    ////////////////////////////////////////////////////////////////////////////
    // Status and interrupt output
    logic [STAT_WIDTH-1:0] stat;
    logic [STAT_WIDTH-1:0] events;
    logic [STAT_WIDTH-1:0] clrMask;
    logic [STAT_WIDTH-1:0] next_stat;

    assign events    = {pin2Ev, matchEv};
    assign clrMask   = wrStat ? pwdata[STAT_WIDTH-1:0] : '0;
    // A new event outranks a write-one-to-clear in the same cycle
    assign next_stat = (stat & ~clrMask) | events;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stat <= RST_STAT;
        end else begin
            stat <= next_stat;
        end
    end

    // Level output, gated by the mask
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq       <= 1'b0;
            irqVector <= NO_HANDLER;
        end else begin
            irq       <= |(stat & mask);                                 // R3
            irqVector <= (stat[STAT_PIN2_BIT] && mask[STAT_PIN2_BIT]) ?
                         PIN2_HANDLER : NO_HANDLER;                      // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer
    logic [31:0] topRead;
    logic [31:0] chRead;
    logic [31:0] readMux;

    assign topRead = (paddr == ADDR_CTRL)   ? {24'h0, ctrl} :
                     (paddr == ADDR_STAT)   ? {27'h0, stat} :
                     (paddr == ADDR_MASK)   ? {27'h0, mask} :
                     (paddr == ADDR_PINCFG) ? {30'h0, pinCfg} :
                     {24'h0, irqVector};
    // Halves read live; software reading both should stop the channel first
    assign chRead  = (chOfs == OFS_MODE)   ? {28'h0, mode[chIdx]} :
                     (chOfs == OFS_PVLO)   ? {16'h0, pv[chIdx][15:0]} :
                     (chOfs == OFS_PVHI)   ? {16'h0, pv[chIdx][31:16]} :
                     (chOfs == OFS_PRESET) ? preset[chIdx] :
                     (chOfs == OFS_RING)   ? ringMax[chIdx] :
                     freq[chIdx];
    assign readMux = isTop ? topRead : isChan ? chRead : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // APB response: answer ready in the first access cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbSetup;
            pslverr <= apbSetup && !mapped;
            if (apbSetup && !pwrite)
                prdata <= readMux;
        end
    end

endmodule : hsc_counter

// *** hdl/hsc_pkg.sv ***
// Constants, register map and shared arithmetic of the pulse counter block.
// Assumes a single 250 MHz core clock and a 32-bit APB register port.
package hsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry and timing
    localparam int          CH_COUNT      = 4;
    localparam int          CLK_MHZ       = 250;
    localparam int          GATE_TIME_MS  = 1000;                       // Speed window, ms
    localparam int unsigned GATE_CYCLES   = GATE_TIME_MS * CLK_MHZ * 1000;

    ////////////////////////////////////////////////////////////////////////////
    // Global register byte addresses
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STAT     = 12'h004;
    localparam logic [11:0] ADDR_MASK     = 12'h008;
    localparam logic [11:0] ADDR_PINCFG   = 12'h00c;
    localparam logic [11:0] ADDR_VECTOR   = 12'h010;

    // Channel c sits at 0x20*(c+1)
    localparam logic [2:0]  CH_FIRST      = 3'h1;
    localparam logic [2:0]  CH_LAST       = 3'h4;
    localparam logic [4:0]  OFS_MODE      = 5'h00;
    localparam logic [4:0]  OFS_PVLO      = 5'h04;
    localparam logic [4:0]  OFS_PVHI      = 5'h08;
    localparam logic [4:0]  OFS_PRESET    = 5'h0c;
    localparam logic [4:0]  OFS_RING      = 5'h10;
    localparam logic [4:0]  OFS_FREQ      = 5'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          CTRL_RUN_LSB  = 0;
    localparam int          CTRL_RST_LSB  = 4;
    localparam int          STAT_PIN2_BIT = 4;
    localparam int          STAT_WIDTH    = 5;
    localparam int          PCFG_INT_BIT  = 0;
    localparam int          PCFG_FALL_BIT = 1;
    localparam int          MODE_RING_BIT = 2;
    localparam int          MODE_ZRST_BIT = 3;

    // Input method codes in MODE[1:0]
    localparam logic [1:0]  METH_INC      = 2'h0;
    localparam logic [1:0]  METH_QUAD     = 2'h1;
    localparam logic [1:0]  METH_UPDN     = 2'h2;
    localparam logic [1:0]  METH_PDIR     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed codes
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [4:0]  RST_STAT      = 5'h00;
    localparam logic [4:0]  RST_MASK      = 5'h00;
    localparam logic [1:0]  RST_PINCFG    = 2'h0;                       // Normal input, rising
    localparam logic [3:0]  RST_MODE      = 4'h0;
    localparam logic [31:0] RST_PRESET    = 32'h0000_0000;
    localparam logic [31:0] RST_RING      = 32'h0000_ffff;
    localparam logic [7:0]  PIN2_HANDLER  = 8'h8e;                      // Handler 142
    localparam logic [7:0]  NO_HANDLER    = 8'h00;

    // One count step, wrapping at the ring maximum in ring mode
    function automatic logic [31:0] hsc_step(input logic [31:0] pv, input logic up,
                                             input logic ring, input logic [31:0] maxv);
        if (ring && up && pv >= maxv)
            return 32'h0000_0000;
        if (ring && !up && pv == 32'h0000_0000)
            return maxv;
        return up ? 32'(pv + 32'h1) : 32'(pv - 32'h1);
    endfunction : hsc_step

endpackage : hsc_pkg

// *** hdl/hsc_sync.sv ***
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the reset given is already synchronous to the clock.
`timescale 1ns/1ps
module hsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1;

    // Only the second stage is seen by anyone
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : hsc_sync

// *** hdl/hsc_decode.sv ***
// Turns synchronised A/B levels of one channel into up and down count pulses.
// Assumes inputs are already synchronised to core_clk.
`timescale 1ns/1ps
module hsc_decode
    import hsc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Channel inputs
    input  wire logic [1:0] method,
    input  wire logic       inA,
    input  wire logic       inB,
    // Count pulses
    output logic            up,
    output logic            dn
);

    logic prevA;
    logic prevB;

    // Previous levels for edge detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prevA <= 1'b0;
            prevB <= 1'b0;
        end else begin
            prevA <= inA;
            prevB <= inB;
        end
    end

    wire riseA  = inA && !prevA;
    wire riseB  = inB && !prevB;
    // 4x: one count per edge of either phase; A leading B counts up
    wire quadEv = inA ^ prevA ^ inB ^ prevB;
    wire quadUp = inA ^ prevB;

    // Per-method selection
    assign up = (method == METH_INC)  ? riseA :
                (method == METH_QUAD) ? (quadEv && quadUp) :
                (method == METH_UPDN) ? riseA : (riseA && !inB);
    assign dn = (method == METH_INC)  ? 1'b0 :
                (method == METH_QUAD) ? (quadEv && !quadUp) :
                (method == METH_UPDN) ? riseB : (riseA && inB);

endmodule : hsc_decode

// *** verification/hsc_enc.sv ***
// Behavioural encoder and pulse source on the counter pins.
// Assumes callers run on core_clk; every pin starts low.
`timescale 1ns/1ps
module hsc_enc (
    // Clock
    input  wire logic core_clk,
    // Pins toward the counter
    output logic [3:0] chanA,
    output logic [3:0] chanB,
    output logic [3:0] chanZ,
    output logic       pinTwo
);
    logic [1:0] phase [4] = '{default: 2'h0};

    ////////////////////////////////////////////////////////////
    // Quiet pins at time zero
    initial {chanA, chanB, chanZ, pinTwo} = '0;

    // One level change, held well past the two-cycle minimum
    task automatic set(input int c, input logic [1:0] ln, input logic v);
        @(posedge core_clk);
        case (ln)
            2'd0: chanA[c] <= v;
            2'd1: chanB[c] <= v;
            2'd2: chanZ[c] <= v;
            default: pinTwo <= v;
        endcase
        repeat (4) @(posedge core_clk);
    endtask : set

    task automatic pulse(input int c, input logic [1:0] ln);
        set(c, ln, 1'b1);
        set(c, ln, 1'b0);
    endtask : pulse

    // Gray step, A leads B when counting up
    task automatic step(input int c, input bit up);
        phase[c] = up ? phase[c] + 2'd1 : phase[c] - 2'd1;
        @(posedge core_clk);
        chanA[c] <= phase[c][1] ^ phase[c][0];
        chanB[c] <= phase[c][1];
        repeat (4) @(posedge core_clk);
    endtask : step
endmodule : hsc_enc

// *** verification/hsc_counter_assertions.sv ***
// Checker for the counter's APB answers and interrupt outputs.
// Assumes it is bound to hsc_counter and sees only its ports.
`timescale 1ns/1ps
module hsc_counter_assertions
    import hsc_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin
    input wire logic        interrupt_pin_two,
    // Interrupt
    input wire logic        irq,
    input wire logic [7:0]  irqVector
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [4:0] maskCopy;
    logic [1:0] pinCfg;
    wire        wrDone = psel && penable && pready && pwrite;

    ////////////////////////////////////////////////////////////
    // Shadow of mask and pin set-up
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            maskCopy <= RST_MASK;
            pinCfg   <= RST_PINCFG;
        end else begin
            if (wrDone && paddr == ADDR_MASK)
                maskCopy <= pwdata[4:0];
            if (wrDone && paddr == ADDR_PINCFG)
                pinCfg <= pwdata[1:0];
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence pin_rise_s;
        $rose(interrupt_pin_two) && pinCfg[PCFG_INT_BIT] && !pinCfg[PCFG_FALL_BIT] && maskCopy[STAT_PIN2_BIT];
    endsequence

    ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready not one cycle");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned not refused");
    err_range_a: assert property (pready && paddr > 12'h094 |-> pslverr)
        else $error("address past channels not refused");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    vec_code_a: assert property (irqVector == PIN2_HANDLER || irqVector == NO_HANDLER)
        else $error("bad handler number");
    vec_irq_a: assert property (irqVector == PIN2_HANDLER |-> ##[0:1] irq)
        else $error("handler without irq");
    irq_mask_a: assert property (irq |-> maskCopy != 5'h0 || $past(maskCopy) != 5'h0)
        else $error("irq with all masked");
    pin_event_a: assert property (pin_rise_s |-> ##[3:6] irqVector == PIN2_HANDLER)
        else $error("pin edge gave no handler");
    pin_quiet_a: assert property (!maskCopy[4] && !$past(maskCopy[4]) |-> irqVector == NO_HANDLER)
        else $error("handler while masked");
endmodule : hsc_counter_assertions

bind hsc_counter hsc_counter_assertions chk_i (.*);

// *** verification/tb.sv ***
// Self-checking bench: APB master, counting model and encoder.
// Assumes hsc_counter, hsc_enc and the bound checker are compiled.
`timescale 1ns/1ps
module tb;
    import hsc_pkg::*;
    localparam int unsigned Gate = 1000;   // Short speed window
    logic        core_clk, resetn, psel, penable, pwrite;
    logic        pready, pslverr, irq, e, interrupt_pin_two;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, seed;
    logic [3:0]  chanA, chanB, chanZ;
    logic [7:0]  irqVector, ctrl;
    int          failures, checked, n;
    int unsigned pv [4], mx [4];
    bit          ringOn [4];

    ////////////////////////////////////////////////////////////
    // Clock, design and encoder
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    hsc_counter #(.GateCycles(Gate)) dut (.*);
    hsc_enc enc (.*, .pinTwo(interrupt_pin_two));

    // Random source, address and model helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [11:0] cb(input int c, input logic [4:0] o);
        return 12'(32 * (c + 1)) + 12'(o);
    endfunction : cb
    function automatic int unsigned mstep(input int unsigned v, input bit up, input bit rg, input int unsigned m);
        if (rg)
            return up ? (v >= m ? 0 : v + 1) : (v == 0 ? m : v - 1);
        return up ? v + 1 : v - 1;
    endfunction : mstep
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            failures++;
            $display("Error at %0t: got %h exp %h", $time, g, x);
        end
    endtask : chk
    // Setup, then hold until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rdat, x);
    endtask : rd
    task automatic wrc(input logic [7:0] v);
        ctrl = v;
        apb(1'b1, ADDR_CTRL, {24'h0, v});
    endtask : wrc
    // Channel c runs method c; the model steps only while running
    task automatic act(input int c, input bit up);
        case (c)
            1: enc.step(c, up);
            2: enc.pulse(c, up ? 2'd0 : 2'd1);
            3: begin
                enc.set(c, 2'd1, !up);
                enc.pulse(c, 2'd0);
            end
            default: enc.pulse(c, 2'd0);
        endcase
        if (ctrl[c] && !ctrl[c + 4])
            pv[c] = mstep(pv[c], up, ringOn[c], mx[c]);
    endtask : act
    task automatic end_sim();
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_sim();
    end

    initial begin
        seed = 32'd20;
        {resetn, psel, penable, pwrite, paddr, pwdata, ctrl} = '0;
        foreach (mx[c]) mx[c] = 32'hffff;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Reset values and an unmapped word
        rd(ADDR_PINCFG, 32'(RST_PINCFG));
        rd(cb(0, OFS_RING), RST_RING);
        rd(ADDR_VECTOR, 32'(NO_HANDLER));
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Methods 1 to 3: one step down, then every method random steps up
        for (int c = 0; c < 4; c++) apb(1'b1, cb(c, OFS_MODE), 32'(c));
        wrc(8'h0f);
        n = int'(xs() % 6) + 2;
        for (int c = 1; c < 4; c++) act(c, 1'b0);
        rd(cb(2, OFS_PVHI), 32'hffff);
        for (int c = 0; c < 4; c++) repeat (n) act(c, 1'b1);
        for (int c = 0; c < 4; c++) rd(cb(c, OFS_PVLO), pv[c]);
        rd(ADDR_STAT, 32'he);
        apb(1'b1, ADDR_STAT, 32'hf);
        wrc(8'h0e);
        act(0, 1'b1);
        rd(cb(0, OFS_PVLO), pv[0]);
        // Preset match, pending while masked
        apb(1'b1, cb(3, OFS_PRESET), pv[3] + 1);
        act(3, 1'b1);
        rd(ADDR_STAT, 32'h8);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h8);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h8);
        rd(ADDR_STAT, 32'h0);
        // Ring of three, software and phase-Z reset
        ringOn[0] = 1'b1;
        mx[0] = 2;
        apb(1'b1, cb(0, OFS_MODE), 32'h4);
        apb(1'b1, cb(0, OFS_RING), 32'h2);
        apb(1'b1, cb(0, OFS_PVLO), 32'h0);
        pv[0] = 0;
        wrc(8'h0f);
        repeat (4) act(0, 1'b1);
        rd(cb(0, OFS_PVLO), pv[0]);
        rd(ADDR_STAT, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h1);
        wrc(8'h1f);
        pv[0] = 0;
        act(0, 1'b1);
        rd(cb(0, OFS_PVLO), 32'h0);
        apb(1'b1, cb(1, OFS_MODE), 32'h9);
        wrc(8'h2f);
        rd(cb(1, OFS_PVLO), pv[1]);
        enc.set(1, 2'd2, 1'b1);
        rd(cb(1, OFS_PVLO), 32'h0);
        // Pin two: plain, masked, unmasked, falling
        enc.pulse(0, 2'd3);
        rd(ADDR_STAT, 32'h0);
        apb(1'b1, ADDR_PINCFG, 32'h1);
        enc.set(0, 2'd3, 1'b1);
        rd(ADDR_VECTOR, 32'h0);
        rd(ADDR_STAT, 32'h10);
        apb(1'b1, ADDR_STAT, 32'h10);
        rd(ADDR_STAT, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h10);
        enc.set(0, 2'd3, 1'b0);
        enc.set(0, 2'd3, 1'b1);
        rd(ADDR_VECTOR, 32'(PIN2_HANDLER));
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h10);
        repeat (2) @(negedge core_clk);
        chk({24'h0, irqVector}, 32'h0);
        apb(1'b1, ADDR_PINCFG, 32'h3);
        enc.set(0, 2'd3, 1'b0);
        rd(ADDR_STAT, 32'h10);
        // Speed over two busy windows, pulse every ten cycles
        repeat (2 * Gate / 10) act(0, 1'b1);
        apb(1'b0, cb(0, OFS_FREQ), 32'h0);
        chk((rdat >= Gate / 10 - 2 && rdat <= Gate / 10 + 2) ? Gate / 10 : rdat, Gate / 10);
        rd(cb(0, OFS_PVLO), pv[0]);
        end_sim();
    end
endmodule : tb
